// ===== verilog/msc_regs.sv
`include "msc_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

module msc_regs #(
    parameter int MS_CYCLES = `MSC_MS_NS / `MSC_CLK_PERIOD_NS
) (
    // clock, reset, enable
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [11:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // motor side
    input  wire logic        start_i,
    input  wire logic        stop_i,
    input  wire logic        zero_cross_i,
    input  wire logic        spin_reverse_i,
    input  wire logic [11:0] speed_dhz_i,
    // start-up control outputs
    output logic      [2:0]  state_o,
    output logic      [10:0] drive_current_ma_o,
    output logic      [5:0]  brake_current_ma_o,
    output logic      [5:0]  hysteresis_mv_o,
    output logic      [12:0] ramp_rate_mvcc_o,
    output logic             accel_range_slow_o,
    output logic      [2:0]  accel2_code_o,
    output logic      [2:0]  accel1_code_o,
    output logic      [11:0] handover_dhz_o
);

    localparam int PW = $clog2(MS_CYCLES + 1);
    localparam logic [PW-1:0] MS_LAST = PW'(MS_CYCLES - 1);
    localparam logic [11:0] ADR3 = {2'h0, `MSC_BRAKE_STARTUP_IDX, 2'h0};
    localparam logic [11:0] ADR4 = {2'h0, `MSC_ACCEL_HANDOVER_IDX, 2'h0};

    // ----------------------------------------------------------------
    // register bus
    // ----------------------------------------------------------------
    logic [15:0] brake_startup_config;
    logic [14:0] accel_handover_config;
    logic [15:0] next_b3;
    logic [14:0] next_a4;
    logic        next_ack;
    logic [31:0] next_dat;
    logic        req;

    assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

    always_comb begin
        next_b3  = brake_startup_config;
        next_a4  = accel_handover_config;
        next_ack = req;
        next_dat = 32'h0000_0000;
        if (req && wb_we_i && wb_adr_i == ADR3) begin
            if (wb_sel_i[0]) next_b3[7:0] = wb_dat_i[7:0];
            if (wb_sel_i[1]) next_b3[15:8] = wb_dat_i[15:8];
        end
        if (req && wb_we_i && wb_adr_i == ADR4) begin
            if (wb_sel_i[0]) next_a4[7:0] = wb_dat_i[7:0];
            // bit 15 is not stored, a write to it has no effect
            if (wb_sel_i[1]) next_a4[14:8] = wb_dat_i[14:8];
        end
        if (req && !wb_we_i) begin
            case (wb_adr_i)
                ADR3:    next_dat = {16'h0000, brake_startup_config};
                ADR4:    next_dat = {17'h00000, accel_handover_config};
                default: next_dat = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            brake_startup_config  <= `MSC_BRAKE_STARTUP_RST;
            accel_handover_config <= 15'(`MSC_ACCEL_HANDOVER_RST);
            wb_ack_o              <= 1'b0;
            wb_dat_o              <= 32'h0000_0000;
        end else if (ce_i) begin
            brake_startup_config  <= next_b3;
            accel_handover_config <= next_a4;
            wb_ack_o              <= next_ack;
            wb_dat_o              <= next_dat;
        end
    end

    // ----------------------------------------------------------------
    // zero-cross synchroniser
    // ----------------------------------------------------------------
    logic zc_meta;
    logic zc_sync;
    logic zc_prev;
    logic zc_edge;

    assign zc_edge = zc_sync & ~zc_prev;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            zc_meta <= 1'b0;
            zc_sync <= 1'b0;
            zc_prev <= 1'b0;
        end else if (ce_i) begin
            zc_meta <= zero_cross_i;
            zc_sync <= zc_meta;
            zc_prev <= zc_sync;
        end
    end

    // ----------------------------------------------------------------
    // decode of the sampled settings
    // ----------------------------------------------------------------
    logic [15:0] sh3;
    logic [14:0] sh4;
    logic [12:0] stat_ms;
    logic [12:0] brk_ms;
    logic [12:0] align_ms;
    logic [11:0] rvs_dhz;
    logic [11:0] hand_dhz;
    logic [12:0] ramp;
    logic [10:0] ol_ma;
    logic [10:0] al_ma;
    logic [3:0]  hand_n;
    logic        brk_on;

    assign hand_n = sh4[`MSC_HAND_LSB +: 4];
    assign brk_on = sh3[`MSC_BRK_DUR_LSB +: 3] != 3'h0;

    always_comb begin
        stat_ms = `MSC_STAT_BASE_MS << sh3[`MSC_STAT_THR_LSB +: 2];
        ol_ma   = 11'h0c8 << sh3[`MSC_OL_CUR_LSB +: 2];
        al_ma   = 11'h096 << sh3[`MSC_OL_CUR_LSB +: 2];
        case (sh3[`MSC_RVS_THR_LSB +: 2])
            2'h0:    rvs_dhz = 12'h03f;
            2'h1:    rvs_dhz = 12'h082;
            2'h2:    rvs_dhz = 12'h104;
            default: rvs_dhz = 12'h1fe;
        endcase
        case (sh3[`MSC_RAMP_LSB +: 3])
            3'h0:    ramp = 13'h1770;
            3'h1:    ramp = 13'h0bb8;
            3'h2:    ramp = 13'h05dc;
            3'h3:    ramp = 13'h02bc;
            3'h4:    ramp = 13'h0154;
            3'h5:    ramp = 13'h00a0;
            3'h6:    ramp = 13'h0046;
            default: ramp = 13'h0017;
        endcase
        case (sh3[`MSC_BRK_DUR_LSB +: 3])
            3'h1:    brk_ms = 13'h0a8c;
            3'h2:    brk_ms = 13'h0514;
            3'h3:    brk_ms = 13'h029e;
            3'h4:    brk_ms = 13'h014a;
            3'h5:    brk_ms = 13'h00a0;
            3'h6:    brk_ms = 13'h0050;
            3'h7:    brk_ms = 13'h0028;
            default: brk_ms = 13'h0000;
        endcase
        case (sh4[`MSC_ALIGN_LSB +: 3])
            3'h0:    align_ms = 13'h14b4;
            3'h1:    align_ms = 13'h0a8c;
            3'h2:    align_ms = 13'h0514;
            3'h3:    align_ms = 13'h029e;
            3'h4:    align_ms = 13'h014a;
            3'h5:    align_ms = 13'h00a0;
            3'h6:    align_ms = 13'h0050;
            default: align_ms = 13'h0028;
        endcase
        if (sh4[`MSC_HAND_LSB + 4]) begin
            hand_dhz = {({1'b0, hand_n} + 5'h01), 7'h00};
        end else if (hand_n == 4'h0) begin
            hand_dhz = 12'h008; // not applicable code, held at the lowest step
        end else begin
            hand_dhz = {5'h00, hand_n, 3'h0};
        end
    end

    // ----------------------------------------------------------------
    // start-up sequencer
    // ----------------------------------------------------------------
    msc_pkg::msc_state_t state;
    msc_pkg::msc_state_t next_state;
    msc_pkg::msc_state_t after_isd;
    logic [PW-1:0] pre;
    logic [PW-1:0] next_pre;
    logic [12:0]   tmr;
    logic [12:0]   next_tmr;
    logic [15:0]   next_sh3;
    logic [14:0]   next_sh4;
    logic [10:0]   next_drive;
    logic          ms_tick;

    assign ms_tick = pre == MS_LAST;

    always_comb begin
        next_state = state;
        next_sh3   = sh3;
        next_sh4   = sh4;
        after_isd  = brk_on ? msc_pkg::MSC_BRAKE : msc_pkg::MSC_ALIGN;
        case (state)
            msc_pkg::MSC_IDLE: begin
                if (start_i) begin
                    next_sh3 = brake_startup_config;
                    next_sh4 = accel_handover_config;
                    if (brake_startup_config[`MSC_ISD_EN_BIT]) begin
                        next_state = msc_pkg::MSC_ISD;
                    end else if (brake_startup_config[`MSC_BRK_DUR_LSB +: 3] != 3'h0) begin
                        next_state = msc_pkg::MSC_BRAKE;
                    end else begin
                        next_state = msc_pkg::MSC_ALIGN;
                    end
                end
            end
            msc_pkg::MSC_ISD: begin
                if (zc_edge && spin_reverse_i && speed_dhz_i <= rvs_dhz) begin
                    if (sh3[`MSC_RVS_EN_BIT]) begin
                        next_state = msc_pkg::MSC_REVERSE;
                    end else if (brk_on) begin
                        next_state = msc_pkg::MSC_BRAKE;
                    end
                end else if (zc_edge && !spin_reverse_i && speed_dhz_i >= hand_dhz) begin
                    next_state = msc_pkg::MSC_CLOSED;
                end else if (!zc_edge && tmr >= stat_ms) begin
                    next_state = after_isd;
                end
            end
            msc_pkg::MSC_REVERSE: begin
                // drive on until the rotor has turned round
                if (!spin_reverse_i) begin
                    next_state = msc_pkg::MSC_OPEN;
                end
            end
            msc_pkg::MSC_BRAKE: begin
                if (tmr >= brk_ms) begin
                    next_state = msc_pkg::MSC_ALIGN;
                end
            end
            msc_pkg::MSC_ALIGN: begin
                if (tmr >= align_ms) begin
                    next_state = msc_pkg::MSC_OPEN;
                end
            end
            msc_pkg::MSC_OPEN: begin
                if (speed_dhz_i >= hand_dhz) begin
                    next_state = msc_pkg::MSC_CLOSED;
                end
            end
            msc_pkg::MSC_CLOSED: next_state = state;
            default:             next_state = msc_pkg::MSC_IDLE;
        endcase
        if (stop_i) begin
            next_state = msc_pkg::MSC_IDLE;
        end
        // every phase starts its time from zero; a zero cross restarts the window
        if (next_state != state || (state == msc_pkg::MSC_ISD && zc_edge)) begin
            next_pre = '0;
            next_tmr = 13'h0000;
        end else begin
            next_pre = ms_tick ? '0 : pre + PW'(1);
            next_tmr = (ms_tick && tmr != 13'h1fff) ? tmr + 13'h0001 : tmr;
        end
        case (state)
            msc_pkg::MSC_ALIGN:   next_drive = al_ma;
            msc_pkg::MSC_REVERSE,
            msc_pkg::MSC_OPEN,
            msc_pkg::MSC_CLOSED:  next_drive = ol_ma;
            default:              next_drive = 11'h000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state              <= msc_pkg::MSC_IDLE;
            pre                <= '0;
            tmr                <= 13'h0000;
            sh3                <= `MSC_BRAKE_STARTUP_RST;
            sh4                <= 15'(`MSC_ACCEL_HANDOVER_RST);
            state_o            <= 3'h0;
            drive_current_ma_o <= 11'h000;
            brake_current_ma_o <= 6'h18;
            hysteresis_mv_o    <= 6'h14;
            ramp_rate_mvcc_o   <= 13'h1770;
            accel_range_slow_o <= 1'b0;
            accel2_code_o      <= 3'h0;
            accel1_code_o      <= 3'h0;
            handover_dhz_o     <= 12'h008;
        end else if (ce_i) begin
            state              <= next_state;
            pre                <= next_pre;
            tmr                <= next_tmr;
            sh3                <= next_sh3;
            sh4                <= next_sh4;
            state_o            <= next_state;
            drive_current_ma_o <= next_drive;
            brake_current_ma_o <= sh3[`MSC_BRK_LVL_BIT] ? 6'h30 : 6'h18;
            hysteresis_mv_o    <= sh3[`MSC_HYS_BIT] ? 6'h28 : 6'h14;
            ramp_rate_mvcc_o   <= ramp;
            accel_range_slow_o <= sh4[`MSC_RANGE_BIT];
            accel2_code_o      <= sh4[`MSC_ACC2_LSB +: 3];
            accel1_code_o      <= sh4[`MSC_ACC1_LSB +: 3];
            handover_dhz_o     <= hand_dhz;
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    sequence s_start_req;
        state == msc_pkg::MSC_IDLE && start_i && !stop_i && ce_i;
    endsequence

    sequence s_wb_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
    endsequence

    a_isd_entry: assert property (@(posedge clk_i) disable iff (rst_i)
        s_start_req ##0 brake_startup_config[`MSC_ISD_EN_BIT] |=> state == msc_pkg::MSC_ISD)
        else $error("start with detect enabled did not enter detect");
    a_isd_skip: assert property (@(posedge clk_i) disable iff (rst_i)
        s_start_req ##0 !brake_startup_config[`MSC_ISD_EN_BIT] |=> state != msc_pkg::MSC_ISD)
        else $error("detect entered while disabled");
    a_reverse_gate: assert property (@(posedge clk_i) disable iff (rst_i)
        state == msc_pkg::MSC_REVERSE |-> sh3[`MSC_RVS_EN_BIT])
        else $error("reverse drive without enable");
    a_brake_level: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i |=> brake_current_ma_o == ($past(sh3[`MSC_BRK_LVL_BIT]) ? 6'h30 : 6'h18))
        else $error("brake level mismatch");
    a_hyst_level: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i |=> hysteresis_mv_o == ($past(sh3[`MSC_HYS_BIT]) ? 6'h28 : 6'h14))
        else $error("hysteresis mismatch");
    a_rsvd_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o && !wb_we_i && wb_adr_i == ADR4 |-> !wb_dat_o[`MSC_RSVD_BIT])
        else $error("reserved bit read as one");
    a_reset_clear: assert property (@(posedge clk_i)
        rst_i |=> brake_startup_config == 16'h0000 && !wb_ack_o)
        else $error("register not cleared by reset");
    a_hand_range1: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && sh4[`MSC_HAND_LSB + 4] |=>
            handover_dhz_o == {({1'b0, $past(hand_n)} + 5'h01), 7'h00})
        else $error("range 1 handover mismatch");
    a_no_brake: assert property (@(posedge clk_i) disable iff (rst_i)
        state == msc_pkg::MSC_BRAKE |-> brk_on)
        else $error("brake with brake disabled");
    a_wb_ack: assert property (@(posedge clk_i) disable iff (rst_i)
        s_wb_req |=> wb_ack_o ##1 !wb_ack_o || !ce_i)
        else $error("ack not a single cycle after request");
    a_shadow_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        state != msc_pkg::MSC_IDLE |=> $stable(sh3) && $stable(sh4))
        else $error("settings changed while running");

endmodule

`default_nettype wire

// ===== verilog/msc_cfg.svh
`ifndef MSC_CFG_SVH
`define MSC_CFG_SVH

// ----------------------------------------------------------------
// register indices and reset values
// ----------------------------------------------------------------
`define MSC_BRAKE_STARTUP_IDX   8'h92
`define MSC_ACCEL_HANDOVER_IDX  8'h93
`define MSC_BRAKE_STARTUP_RST   16'h0000
`define MSC_ACCEL_HANDOVER_RST  16'h0000

// ----------------------------------------------------------------
// field positions, brake_startup_config
// ----------------------------------------------------------------
`define MSC_STAT_THR_LSB        14
`define MSC_BRK_LVL_BIT         13
`define MSC_HYS_BIT             12
`define MSC_ISD_EN_BIT          11
`define MSC_RVS_EN_BIT          10
`define MSC_RVS_THR_LSB         8
`define MSC_OL_CUR_LSB          6
`define MSC_RAMP_LSB            3
`define MSC_BRK_DUR_LSB         0

// ----------------------------------------------------------------
// field positions, accel_handover_config
// ----------------------------------------------------------------
`define MSC_RSVD_BIT            15
`define MSC_RANGE_BIT           14
`define MSC_ACC2_LSB            11
`define MSC_ACC1_LSB            8
`define MSC_HAND_LSB            3
`define MSC_ALIGN_LSB           0

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define MSC_CLK_PERIOD_NS       5
`define MSC_MS_NS               1000000
`define MSC_STAT_BASE_MS        13'h0050

`endif

// ===== verilog/msc_pkg.sv
package msc_pkg;
    typedef enum logic [2:0] {
        MSC_IDLE    = 3'b000,
        MSC_ISD     = 3'b001,
        MSC_REVERSE = 3'b010,
        MSC_BRAKE   = 3'b011,
        MSC_ALIGN   = 3'b100,
        MSC_OPEN    = 3'b101,
        MSC_CLOSED  = 3'b110
    } msc_state_t;
endpackage

// ===== tb/msc_motor_model.sv
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------
// rotor seen through its back-emf sensing
// ----------------------------------------------------------------
module msc_motor_model (
    // clock
    input  wire logic        clk_i,
    // bench control of the rotor
    input  wire logic        spin_i,
    input  wire logic        rev_i,
    input  wire logic [11:0] spd_i,
    // controller side
    input  wire logic [2:0]  state_i,
    output logic             zc_o,
    output logic             rev_o,
    output logic      [11:0] spd_o
);
    logic [3:0] ph = 4'h0;

    always_ff @(posedge clk_i) begin
        ph <= ph + 4'h1;
        // rotor only picks up speed while driven open loop
        if (state_i == 3'h5) begin
            spd_o <= spd_o + 12'h001;
        end else begin
            spd_o <= spin_i ? spd_i : 12'h000;
        end
    end

    // a rotor at rest gives no zero crosses at all
    assign zc_o  = spin_i && ph[3];
    assign rev_o = spin_i && rev_i;
endmodule

`default_nettype wire

// ===== tb/motor_startup_config_regs_tb.sv
`timescale 1ns/100ps
`default_nettype none

module motor_startup_config_regs_tb;
    localparam int MS = 4;
    typedef struct packed {
        logic [15:0] c3;
        logic [15:0] c4;
        logic [15:0] ramp;
        logic [11:0] hand;
        logic [10:0] al;
        logic [10:0] ol;
    } msc_row_t;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        wb_cyc = 1'b0;
    logic        wb_stb = 1'b0;
    logic        wb_we = 1'b0;
    logic [11:0] wb_adr = 12'h000;
    logic [31:0] wb_dat = 32'h0;
    logic [3:0]  wb_sel = 4'h0;
    logic        start_i = 1'b0;
    logic        stop_i = 1'b0;
    logic        spin = 1'b0;
    logic        rev = 1'b0;
    logic [11:0] spd = 12'h000;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o, zc, spin_rev, slow;
    logic [11:0] speed, hand;
    logic [2:0]  state_o, a2, a1;
    logic [10:0] drv;
    logic [5:0]  brk, hys;
    logic [12:0] ramp;
    logic [15:0] q;
    int          error_cnt = 0;
    int          comparisons = 0;
    msc_row_t    rows [8] = '{
        '{16'h0000, 16'h8007, 16'h1770, 12'h008, 11'h096, 11'h0c8},
        '{16'h2048, 16'h0e0f, 16'h0bb8, 12'h008, 11'h12c, 11'h190},
        '{16'h1090, 16'h153e, 16'h05dc, 12'h038, 11'h258, 11'h320},
        '{16'h30d8, 16'h9c7f, 16'h02bc, 12'h078, 11'h4b0, 11'h640},
        '{16'h0020, 16'h6387, 16'h0154, 12'h080, 11'h096, 11'h0c8},
        '{16'h2068, 16'h6a8f, 16'h00a0, 12'h100, 11'h12c, 11'h190},
        '{16'h10b0, 16'h71bf, 16'h0046, 12'h400, 11'h258, 11'h320},
        '{16'h30f8, 16'hf8fe, 16'h0017, 12'h800, 11'h4b0, 11'h640}};

    msc_regs #(.MS_CYCLES(MS)) dut (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
        .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
        .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .start_i(start_i), .stop_i(stop_i), .zero_cross_i(zc), .spin_reverse_i(spin_rev),
        .speed_dhz_i(speed), .state_o(state_o), .drive_current_ma_o(drv),
        .brake_current_ma_o(brk), .hysteresis_mv_o(hys), .ramp_rate_mvcc_o(ramp),
        .accel_range_slow_o(slow), .accel2_code_o(a2), .accel1_code_o(a1),
        .handover_dhz_o(hand));
    msc_motor_model motor (
        .clk_i(clk_i), .spin_i(spin), .rev_i(rev), .spd_i(spd), .state_i(state_o),
        .zc_o(zc), .rev_o(spin_rev), .spd_o(speed));

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic print_verdict();
        if (error_cnt == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    // one classic cycle; entered and left just after a rising edge
    task automatic wb(input logic w, input logic [11:0] a, input logic [15:0] d);
        int n;
        n = 0;
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= w;
        wb_adr <= a;
        wb_sel <= 4'h3;
        wb_dat <= {16'h0000, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        q = wb_dat_o[15:0];
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        @(posedge clk_i);
        chk("ack", 16'h0001, 16'(n < 20));
    endtask

    task automatic wait_st(input logic [2:0] s);
        int n;
        n = 0;
        while (state_o !== s && n < 4000) begin
            @(posedge clk_i);
            n++;
        end
        chk("state", 16'(s), 16'(state_o));
    endtask

    // phase length in cycles; a little slack for the cycles already spent in the phase before the call
    task automatic dwell(input int ms);
        logic [2:0] s;
        int n;
        s = state_o;
        n = 0;
        while (state_o === s && n < 4000) begin
            @(posedge clk_i);
            n++;
        end
        comparisons++;
        if (n < ms * MS - 3 || n > (ms + 2) * MS + 1) begin
            error_cnt++;
            $display("mismatch dwell expected %0d ms seen %0d cycles", ms, n);
        end
    endtask

    task automatic go();
        start_i <= 1'b1;
        @(posedge clk_i);
        start_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic halt();
        stop_i <= 1'b1;
        @(posedge clk_i);
        stop_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic run_row(input msc_row_t r);
        wb(1'b1, 12'h248, r.c3);
        wb(1'b1, 12'h24c, r.c4);
        wb(1'b0, 12'h248, 16'h0000);
        chk("cfg_a", r.c3, q);
        wb(1'b0, 12'h24c, 16'h0000);
        chk("cfg_b", r.c4 & 16'h7fff, q);
        go();
        chk("state", 16'h0004, 16'(state_o));
        @(posedge clk_i);
        chk("drive", 16'(r.al), 16'(drv));
        chk("brake", r.c3[13] ? 16'h0030 : 16'h0018, 16'(brk));
        chk("hyst", r.c3[12] ? 16'h0028 : 16'h0014, 16'(hys));
        chk("ramp", r.ramp, 16'(ramp));
        chk("range", 16'(r.c4[14]), 16'(slow));
        chk("acc2", 16'(r.c4[13:11]), 16'(a2));
        chk("acc1", 16'(r.c4[10:8]), 16'(a1));
        chk("hand", 16'(r.hand), 16'(hand));
        dwell(r.c4[0] ? 40 : 80);
        chk("state", 16'h0005, 16'(state_o));
        repeat (2) @(posedge clk_i);
        chk("drive", 16'(r.ol), 16'(drv));
        wait_st(3'h6);
        chk("spd_lo", 16'h0001, 16'(speed > r.hand));
        chk("spd_hi", 16'h0001, 16'(speed <= r.hand + 12'h004));
        halt();
    endtask

    initial begin
        forever #2.5 clk_i = ~clk_i;
    end

    initial begin
        #500000;
        error_cnt++;
        print_verdict();
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        chk("state0", 16'h0000, 16'(state_o));
        chk("ramp0", 16'h1770, 16'(ramp));
        chk("hand0", 16'h0008, 16'(hand));
        wb(1'b0, 12'h248, 16'h0000);
        chk("cfg_a0", 16'h0000, q);
        wb(1'b1, 12'h250, 16'hffff);
        wb(1'b0, 12'h250, 16'h0000);
        chk("unmapped", 16'h0000, q);
        wb(1'b0, 12'h24c, 16'h0000);
        chk("cfg_b0", 16'h0000, q);
        foreach (rows[i]) begin
            run_row(rows[i]);
        end
        // a write while running must wait for the next start
        wb(1'b1, 12'h248, 16'h0000);
        wb(1'b1, 12'h24c, 16'h0007);
        go();
        wb(1'b1, 12'h248, 16'h1000);
        chk("hyst_hold", 16'h0014, 16'(hys));
        halt();
        go();
        @(posedge clk_i);
        chk("hyst_new", 16'h0028, 16'(hys));
        halt();
        for (int k = 0; k < 4; k += 3) begin
            wb(1'b1, 12'h248, {k[1:0], 14'h2807});
            go();
            wait_st(3'h1);
            dwell(80 << k);
            chk("state", 16'h0003, 16'(state_o));
            chk("brake", 16'h0030, 16'(brk));
            dwell(40);
            chk("state", 16'h0004, 16'(state_o));
            halt();
        end
        wb(1'b1, 12'h24c, 16'h00ff);
        spin <= 1'b1;
        rev <= 1'b1;
        for (int k = 0; k < 2; k++) begin
            spd <= 12'h08c;
            wb(1'b1, 12'h248, {5'h01, k[0], 10'h147});
            go();
            repeat (100) @(posedge clk_i);
            chk("state", 16'h0001, 16'(state_o));
            spd <= 12'h082;
            wait_st(k == 1 ? 3'h2 : 3'h3);
            repeat (2) @(posedge clk_i);
            if (k == 1) begin
                chk("drive", 16'h0190, 16'(drv));
                rev <= 1'b0;
                wait_st(3'h5);
            end
            halt();
        end
        spin <= 1'b0;
        // a reset in mid-run clears registers and sequencer alike
        wb(1'b1, 12'h248, 16'h1000);
        go();
        rst_i <= 1'b1;
        @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk("state_rst", 16'h0000, 16'(state_o));
        chk("hyst_rst", 16'h0014, 16'(hys));
        wb(1'b0, 12'h248, 16'h0000);
        chk("cfg_rst", 16'h0000, q);
        print_verdict();
    end
endmodule

`default_nettype wire
